// >>> pcd_cpl_id_fmt.sv
// Chosen here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
// Overview of operation
// - endpoint without ARI: upper five function/device bits are ignored
// - completer-ID-enable high outside endpoint mode: completer ID is bus, device, function from descriptor
// - enable low or endpoint: captured bus plus captured device and descriptor function form completer ID, or with ARI the whole 8-bit descriptor function
// - attributes copied from request: bit0 no-snoop, bit1 relaxed, bit2 ID-based
// - force-ECRC set: completion gets a digest even if ECRC is disabled
module pcd_cpl_id_fmt (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic cfg_cap_valid,
    input wire logic [7:0] cfg_cap_bus,
    input wire logic [4:0] cfg_cap_dev,
    input wire logic desc_valid,
    input wire logic [7:0] desc_func_dev,
    input wire logic [7:0] desc_bus,
    input wire logic desc_cid_en,
    input wire logic [2:0] desc_tc,
    input wire logic [2:0] desc_attr,
    input wire logic desc_force_ecrc,
    input wire logic [15:0] desc_req_id,
    input wire logic [7:0] desc_tag,
    output logic hdr_valid,
    output logic [15:0] hdr_cpl_id,
    output logic [2:0] hdr_tc,
    output logic [2:0] hdr_attr,
    output logic hdr_digest,
    output logic [15:0] hdr_req_id,
    output logic [7:0] hdr_tag
);
    import pcd_pkg::*;

    pcd_state_t s_r;
    pcd_state_t s_nxt;
    logic is_ep;
    logic use_desc;

    function automatic logic [31:0] rd_word(input logic [7:0] a, input pcd_state_t s);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (a)
            PCD_OFF_CTRL: w = {28'h0000000, s.ecrc, s.ari, s.mode};
            PCD_OFF_STATUS: w = {15'h0000, s.dig, s.cid};
            PCD_OFF_COUNT: w = {16'h0000, s.count};
            PCD_OFF_CAPID: w = {19'h00000, s.cap_dev, s.cap_bus};
            default: w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // next-state logic

    assign is_ep = (s_r.mode == PCD_MODE_EP);
    // endpoint forces the captured-ID path whatever the enable bit says
    assign use_desc = desc_cid_en && !is_ep;

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.hv = 1'b0;

        // zero-wait writes; reads take one wait so hrdata comes from a flop
        case (s_r.bst)
            PCD_BUS_RD1:
            begin
                s_nxt.hrdata = rd_word(s_r.raddr, s_r);
                s_nxt.bst = PCD_BUS_RD2;
            end
            PCD_BUS_IDLE, PCD_BUS_WR, PCD_BUS_RD2:
            begin
                if (s_r.bst == PCD_BUS_WR && s_r.raddr == PCD_OFF_CTRL)
                begin
                    s_nxt.mode = hwdata[PCD_CTRL_MODE_LSB +: 2];
                    s_nxt.ari = hwdata[PCD_CTRL_ARI_BIT];
                    s_nxt.ecrc = hwdata[PCD_CTRL_ECRC_BIT];
                end
                if (hsel && htrans[1] && hready)
                begin
                    s_nxt.raddr = {haddr[7:2], 2'h0};
                    s_nxt.bst = hwrite ? PCD_BUS_WR : PCD_BUS_RD1;
                end
                else
                begin
                    s_nxt.bst = PCD_BUS_IDLE;
                end
            end
            default: s_nxt.bst = PCD_BUS_IDLE;
        endcase

        if (cfg_cap_valid)
        begin
            s_nxt.cap_bus = cfg_cap_bus;
            s_nxt.cap_dev = cfg_cap_dev;
        end

        if (desc_valid)
        begin
            s_nxt.hv = 1'b1;
            if (use_desc)
            begin
                s_nxt.cid = {desc_bus, desc_func_dev};
            end
            else if (s_r.ari)
            begin
                s_nxt.cid = {s_r.cap_bus, desc_func_dev};
            end
            else
            begin
                // upper five descriptor bits dropped for the captured device
                s_nxt.cid = {s_r.cap_bus, s_r.cap_dev, desc_func_dev[2:0]};
            end
            s_nxt.tc = desc_tc;
            s_nxt.attr = desc_attr;
            s_nxt.dig = desc_force_ecrc || s_r.ecrc;
            s_nxt.req_id = desc_req_id;
            s_nxt.tag = desc_tag;
            s_nxt.count = s_r.count + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_r <= '{bst: PCD_BUS_IDLE, raddr: 8'h00, hrdata: 32'h0000_0000,
                     mode: PCD_RST_MODE, ari: PCD_RST_ARI, ecrc: PCD_RST_ECRC,
                     cap_bus: PCD_RST_CAP_BUS, cap_dev: PCD_RST_CAP_DEV, hv: 1'b0,
                     cid: 16'h0000, tc: 3'h0, attr: 3'h0, dig: 1'b0,
                     req_id: 16'h0000, tag: 8'h00, count: 16'h0000};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    // only the first data-phase cycle of a read stalls; writes never wait
    assign hreadyout = (s_r.bst != PCD_BUS_RD1);
    assign hresp = 1'b0;
    assign hrdata = s_r.hrdata;
    assign hdr_valid = s_r.hv;
    assign hdr_cpl_id = s_r.cid;
    assign hdr_tc = s_r.tc;
    assign hdr_attr = s_r.attr;
    assign hdr_digest = s_r.dig;
    assign hdr_req_id = s_r.req_id;
    assign hdr_tag = s_r.tag;

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    desc_id_src_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        desc_valid && desc_cid_en && !is_ep |=>
            hdr_valid && hdr_cpl_id == {$past(desc_bus), $past(desc_func_dev)})
        else $error("completer id not taken from descriptor");

    cap_id_src_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        desc_valid && !use_desc |=>
            hdr_cpl_id[15:8] == $past(s_r.cap_bus) &&
            hdr_cpl_id[2:0] == $past(desc_func_dev[2:0]))
        else $error("completer id not built from captured bus");

    ep_dev_ignore_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        desc_valid && is_ep && !s_r.ari |=> hdr_cpl_id[7:3] == $past(s_r.cap_dev))
        else $error("endpoint used descriptor device bits");

    ep_bus_ignore_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        desc_valid && is_ep && desc_bus != s_r.cap_bus |=>
            hdr_cpl_id[15:8] == $past(s_r.cap_bus))
        else $error("endpoint used descriptor bus number");

    attr_copy_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        desc_valid |=> hdr_attr == $past(desc_attr) && hdr_tc == $past(desc_tc))
        else $error("attributes or traffic class not copied");

    force_ecrc_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        desc_valid && desc_force_ecrc |=> hdr_valid && hdr_digest)
        else $error("forced ecrc did not add digest");

    digest_src_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        desc_valid && !desc_force_ecrc |=> hdr_digest == $past(s_r.ecrc))
        else $error("digest does not follow ecrc enable");

    req_copy_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        desc_valid |=> hdr_req_id == $past(desc_req_id) && hdr_tag == $past(desc_tag))
        else $error("requester id or tag not copied");

    desc_count_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        desc_valid |=> s_r.count == $past(s_r.count) + 16'h0001)
        else $error("descriptor count did not step");

    hdr_pulse_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        hdr_valid |-> $past(desc_valid) && hdr_tag == $past(desc_tag))
        else $error("header valid without descriptor");

    rd_wait_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state missing");
endmodule

// >>> pcd_cpl_id_fmt_test.sv
`timescale 1ns/100ps
module pcd_cpl_id_fmt_test;
import pcd_pkg::*;
logic clk_sys, arst_n, go, relay, ari, hwrite, hreadyout, hresp, cfg_v, dv, cid_en, force_e;
logic hdr_valid, hdr_digest, cid_force;
logic [1:0] mode, htrans;
logic [31:0] haddr, hwdata, hrdata, rd;
logic [7:0] cap_bus, fd, bus, tag, hdr_tag;
logic [4:0] cap_dev;
logic [2:0] tc, attr, hdr_tc, hdr_attr;
logic [15:0] req_id, hdr_cpl_id, hdr_req_id;
int err_count, n_tests;
pcd_user_model u_pcd_user_model (.clk_sys(clk_sys), .go(go), .mode(mode), .ari(ari),
    .relay(relay), .func(8'hB5), .dev(5'h0C), .bus(8'hC3), .desc_valid(dv),
    .desc_func_dev(fd), .desc_bus(bus), .desc_cid_en(cid_en));
pcd_cpl_id_fmt u_pcd_cpl_id_fmt (.clk_sys(clk_sys), .arst_n(arst_n), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .cfg_cap_valid(cfg_v), .cfg_cap_bus(cap_bus), .cfg_cap_dev(cap_dev), .desc_valid(dv),
    .desc_func_dev(fd), .desc_bus(bus), .desc_cid_en(cid_en | cid_force), .desc_tc(tc),
    .desc_attr(attr), .desc_force_ecrc(force_e), .desc_req_id(req_id), .desc_tag(tag),
    .hdr_valid(hdr_valid), .hdr_cpl_id(hdr_cpl_id), .hdr_tc(hdr_tc), .hdr_attr(hdr_attr),
    .hdr_digest(hdr_digest), .hdr_req_id(hdr_req_id), .hdr_tag(hdr_tag));
////////////////////////////////////////////////////////////////////////////////
task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
        err_count++;
        $display("BAD %0t got %h exp %h", $time, got, exp);
    end
endtask
task finish_test;
    if (err_count == 0 && n_tests > 0)
        $display("ALL CHECKS OK");
    else
        $display("CHECKS NOT OK");
    $finish;
endtask
// single word transfer; waits on hreadyout, the watchdog bounds a hang
task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge clk_sys iff hreadyout);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_sys iff hreadyout);
    rd = hrdata;
endtask
task run(input logic [1:0] m, input logic a, input logic r, input logic ce, input logic f,
    input logic [15:0] exp);
    ahb(1'b1, PCD_OFF_CTRL, {28'h0, ce, a, m});
    mode <= m;
    ari <= a;
    relay <= r;
    force_e <= f;
    tc <= tc + 3'h3;
    attr <= attr + 3'h5;
    req_id <= req_id + 16'h1357;
    tag <= tag + 8'h4B;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk(hdr_valid, 32'h1);
    chk(hdr_cpl_id, exp);
    chk(hdr_digest, f | ce);
    chk({hdr_tc, hdr_attr}, {tc, attr});
    chk({hdr_req_id, hdr_tag}, {req_id, tag});
    @(posedge clk_sys);
    #1;
    chk(hdr_valid, 32'h0);
endtask
////////////////////////////////////////////////////////////////////////////////
initial
begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
end
initial
begin
    #20000;
    err_count++;
    finish_test;
end
initial
begin
    {arst_n, go, relay, ari, hwrite, cfg_v, force_e, cid_force, mode, htrans} = '0;
    {haddr, hwdata, cap_bus, cap_dev, tc, attr, req_id, tag} = '0;
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
    ahb(1'b0, PCD_OFF_CTRL, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    chk(hresp, 32'h0);
    cap_bus <= 8'h5A;
    cap_dev <= 5'h13;
    cfg_v <= 1'b1;
    @(posedge clk_sys);
    cfg_v <= 1'b0;
    ahb(1'b1, PCD_OFF_CAPID, 32'hFFFFFFFF);
    ahb(1'b0, PCD_OFF_CAPID, 32'h0);
    chk(rd, 32'h0000135A);
    // captured device differs from the descriptor's, so the path taken shows
    // the enable is forced high here to show that endpoint mode ignores it
    cid_force <= 1'b1;
    run(PCD_MODE_EP, 1'b0, 1'b1, 1'b0, 1'b0, 16'h5A9D);
    @(posedge clk_sys);
    cid_force <= 1'b0;
    run(PCD_MODE_EP, 1'b1, 1'b0, 1'b0, 1'b1, 16'h5AB5);
    run(PCD_MODE_SWUP, 1'b0, 1'b0, 1'b1, 1'b0, 16'h5A9D);
    run(PCD_MODE_SWUP, 1'b0, 1'b1, 1'b0, 1'b0, 16'hC365);
    run(PCD_MODE_SWUP, 1'b1, 1'b1, 1'b0, 1'b0, 16'hC3B5);
    run(PCD_MODE_RP, 1'b0, 1'b0, 1'b0, 1'b1, 16'hC365);
    run(PCD_MODE_RP, 1'b1, 1'b0, 1'b1, 1'b1, 16'hC3B5);
    ahb(1'b0, PCD_OFF_STATUS, 32'h0);
    chk(rd, 32'h0001C3B5);
    ahb(1'b0, PCD_OFF_COUNT, 32'h0);
    chk(rd, 32'h7);
    finish_test;
end
endmodule

// >>> pcd_pkg.sv
package pcd_pkg;
    // register byte offsets on the AHB-Lite slave
    localparam logic [7:0] PCD_OFF_CTRL = 8'h00;
    localparam logic [7:0] PCD_OFF_STATUS = 8'h04;
    localparam logic [7:0] PCD_OFF_COUNT = 8'h08;
    localparam logic [7:0] PCD_OFF_CAPID = 8'h0C;

    // control and status register field positions
    localparam int PCD_CTRL_MODE_LSB = 0;
    localparam int PCD_CTRL_ARI_BIT = 2;
    localparam int PCD_CTRL_ECRC_BIT = 3;
    localparam int PCD_STATUS_DIG_BIT = 16;

    // port modes
    localparam logic [1:0] PCD_MODE_EP = 2'h0;
    localparam logic [1:0] PCD_MODE_SWUP = 2'h1;
    localparam logic [1:0] PCD_MODE_RP = 2'h2;

    // reset values
    localparam logic [1:0] PCD_RST_MODE = PCD_MODE_EP;
    localparam logic PCD_RST_ARI = 1'b0;
    localparam logic PCD_RST_ECRC = 1'b0;
    localparam logic [7:0] PCD_RST_CAP_BUS = 8'h00;
    localparam logic [4:0] PCD_RST_CAP_DEV = 5'h00;

    // descriptor field positions, kept for users who slice the raw descriptor
    localparam int PCD_DESC_FUNC_LSB = 80;
    localparam int PCD_DESC_BUS_LSB = 88;
    localparam int PCD_DESC_CIDEN_BIT = 88;
    localparam int PCD_DESC_TC_LSB = 89;
    localparam int PCD_DESC_ATTR_LSB = 92;
    localparam int PCD_DESC_ECRC_BIT = 95;
    localparam int PCD_ATTR_NS_BIT = 0;
    localparam int PCD_ATTR_RO_BIT = 1;
    localparam int PCD_ATTR_IDO_BIT = 2;

    typedef enum logic [3:0] {
        PCD_BUS_IDLE = 4'b0001,
        PCD_BUS_WR = 4'b0010,
        PCD_BUS_RD1 = 4'b0100,
        PCD_BUS_RD2 = 4'b1000
    } pcd_bus_st_t;

    typedef struct packed {
        pcd_bus_st_t bst;
        logic [7:0] raddr;
        logic [31:0] hrdata;
        logic [1:0] mode;
        logic ari;
        logic ecrc;
        logic [7:0] cap_bus;
        logic [4:0] cap_dev;
        logic hv;
        logic [15:0] cid;
        logic [2:0] tc;
        logic [2:0] attr;
        logic dig;
        logic [15:0] req_id;
        logic [7:0] tag;
        logic [15:0] count;
    } pcd_state_t;
endpackage

// >>> pcd_user_model.sv
`timescale 1ns/100ps
module pcd_user_model
    import pcd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic go,
    input wire logic [1:0] mode,
    input wire logic ari,
    input wire logic relay,
    input wire logic [7:0] func,
    input wire logic [4:0] dev,
    input wire logic [7:0] bus,
    output logic desc_valid,
    output logic [7:0] desc_func_dev,
    output logic [7:0] desc_bus,
    output logic desc_cid_en
);
    // outside a descriptor the function/device and bus fields toggle, so stale values cannot pass
    always_ff @(posedge clk_sys)
    begin
        desc_valid <= go;
        desc_func_dev <= go ? (ari ? func : {dev, func[2:0]}) : ~desc_func_dev;
        desc_bus <= go ? bus : ~desc_bus;
        desc_cid_en <= (mode == PCD_MODE_RP) || (mode == PCD_MODE_SWUP && relay);
    end
endmodule
